// ==== include/scatr_pkg.sv ====
// Package with register map, field layout and reset values of the synth cal and tuning registers
//
// Functional notes
// R1: VCO current cal field bits 4:0, written by calibration or software, resets 01010.
// R2: Software may save the three cal registers per channel and restore them on hops.
// R3: Coarse capacitor cal field bits 5:0, written by calibration or software, resets 100000.
// R4: Coarse capacitor register returns to reset when waking from the two deepest sleeps.
// R5: Calibration control field bits 6:0 is read/write, resets 0001101.
// R6: Tuning word A resets to 0x88; software may use 0x81 for low-rate sensitivity.
// R7: Tuning word B resets to 0x11; software sets 0x31 while transmitting.
// R8: Software may set tuning word B to 0x35 while receiving at low rates.
// R9: Low-rate tuning values only while the DC block filter disable bit is 0.
// R10: Tuning word C bit 1 enables VCO choice calibration stage; resets 0000_1011.
// R11: Power entry seven is 8-bit read/write, resets 0x00.
// R12: Power index select picks the transmit entry; entries 0..index step for ramping.
// R13: VCO current cal bit 5 selects high VCO core when 1, resets 0.
// R14: Unused bits read zero and ignore writes.
package scatr_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // ****************
    // Register offsets
    // ****************
    localparam logic [15:0] ADDR_VCO_CURRENT_CAL = 16'hdf1d;
    localparam logic [15:0] ADDR_VCO_COARSE_CAP_CAL = 16'hdf1e;
    localparam logic [15:0] ADDR_SYNTH_CAL_CONTROL = 16'hdf1f;
    localparam logic [15:0] ADDR_TUNING_WORD_A = 16'hdf23;
    localparam logic [15:0] ADDR_TUNING_WORD_B = 16'hdf24;
    localparam logic [15:0] ADDR_TUNING_WORD_C = 16'hdf25;
    localparam logic [15:0] ADDR_POWER_LEVEL_ENTRY_SEVEN = 16'hdf27;

    // ***************************
    // Writable masks, reset values
    // ***************************
    localparam logic [7:0] MASK_VCO_CURRENT_CAL = 8'h3f;
    localparam logic [7:0] MASK_VCO_COARSE_CAP_CAL = 8'h3f;
    localparam logic [7:0] MASK_SYNTH_CAL_CONTROL = 8'h7f;
    localparam logic [7:0] RST_VCO_CURRENT_CAL = 8'h0a;
    localparam logic [7:0] RST_VCO_COARSE_CAP_CAL = 8'h20;
    localparam logic [7:0] RST_SYNTH_CAL_CONTROL = 8'h0d;
    localparam logic [7:0] RST_TUNING_WORD_A = 8'h88;
    localparam logic [7:0] RST_TUNING_WORD_B = 8'h11;
    localparam logic [7:0] RST_TUNING_WORD_C = 8'h0b;
    localparam logic [7:0] RST_POWER_LEVEL_ENTRY_SEVEN = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // ***************
    // Field positions
    // ***************
    localparam int VCO_HIGH_CORE_SELECT_BIT = 5;
    localparam int VCO_CHOICE_CAL_ENABLE_BIT = 1;
    localparam int VCO_CURRENT_MSB = 4;
    localparam int COARSE_CAP_MSB = 5;
    localparam int CAL_CONTROL_MSB = 6;
    localparam logic [2:0] TOP_POWER_INDEX = 3'h7;
endpackage

// ==== include/scatr_cal_if.sv ====
// Interface carrying calibration results from the synthesizer into the register bank
`timescale 1ns/10ps
`default_nettype none
interface scatr_cal_if;
    logic cal_current_we;
    logic [4:0] cal_current;
    logic cal_coarse_we;
    logic [5:0] cal_coarse;
    modport sink (input cal_current_we, input cal_current, input cal_coarse_we, input cal_coarse);
    modport source (output cal_current_we, output cal_current, output cal_coarse_we,
        output cal_coarse);
endinterface
`default_nettype wire

// ==== src/scatr_power_sel.sv ====
// Power level selection and ramp stepping over entries zero up to the chosen index
`timescale 1ns/10ps
`default_nettype none
module scatr_power_sel (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Control
    input wire logic [2:0] power_index_select,
    input wire logic ramp_up,
    input wire logic ramp_down,
    // Table
    input wire logic [7:0] power_level_entry_seven,
    input wire logic [7:0] power_level_low [7],
    // Result
    output logic [2:0] power_index,
    output logic [7:0] power_level
);
    logic [2:0] idx_r;

    // *****************
    // Ramp index stepping
    // *****************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            idx_r <= 3'h0;
        end else if (ramp_up && idx_r < power_index_select) begin
            idx_r <= idx_r + 3'h1; // R12
        end else if (ramp_down && idx_r != 3'h0) begin
            idx_r <= idx_r - 3'h1; // R12
        end else if (!ramp_up && !ramp_down && idx_r > power_index_select) begin
            idx_r <= power_index_select;
        end
    end

    assign power_index = idx_r;
    always_comb begin
        if (idx_r == scatr_pkg::TOP_POWER_INDEX) begin
            power_level = power_level_entry_seven; // R12
        end else begin
            power_level = power_level_low[idx_r];
        end
    end
endmodule
`default_nettype wire

// ==== src/scatr_regs.sv ====
// Register bank for synthesizer calibration, tuning words and power entry seven
`timescale 1ns/10ps
`default_nettype none
module scatr_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Calibration results and sleep wake
    input wire logic cal_current_we,
    input wire logic [4:0] cal_current,
    input wire logic cal_coarse_we,
    input wire logic [5:0] cal_coarse,
    input wire logic deep_sleep_wake,
    // Power control
    input wire logic [2:0] power_index_select,
    input wire logic ramp_up,
    input wire logic ramp_down,
    input wire logic [7:0] power_level_low [7],
    // Outputs to analog
    output logic [4:0] vco_current_cal,
    output logic vco_high_core_select,
    output logic [5:0] vco_coarse_cap_cal,
    output logic [6:0] synth_cal_control,
    output logic [7:0] tuning_word_a,
    output logic [7:0] tuning_word_b,
    output logic [7:0] tuning_word_c,
    output logic vco_choice_cal_enable,
    output logic [2:0] power_index,
    output logic [7:0] power_level
);
    // Slot of each mapped register in the decode tables
    localparam int REG_COUNT = 7;
    localparam int IDX_CUR = 0;
    localparam int IDX_COARSE = 1;
    localparam int IDX_CTL = 2;
    localparam int IDX_TWA = 3;
    localparam int IDX_TWB = 4;
    localparam int IDX_TWC = 5;
    localparam int IDX_PE7 = 6;

    logic [7:0] cur_r;
    logic [7:0] coarse_r;
    logic [7:0] ctl_r;
    logic [7:0] twa_r;
    logic [7:0] twb_r;
    logic [7:0] twc_r;
    logic [7:0] pe7_r;
    logic [7:0] rdata_r;
    logic [7:0] rd_nxt;
    logic [15:0] reg_addr [REG_COUNT];
    logic [7:0] reg_word [REG_COUNT];
    logic [7:0] rd_term [REG_COUNT];
    logic [REG_COUNT-1:0] addr_hit;
    logic [REG_COUNT-1:0] wr_hit;

    // ****************************
    // Calibration results, grouped
    // ****************************
    scatr_cal_if cal ();
    assign cal.cal_current_we = cal_current_we;
    assign cal.cal_current = cal_current;
    assign cal.cal_coarse_we = cal_coarse_we;
    assign cal.cal_coarse = cal_coarse;

    // **************
    // Address decode
    // **************
    assign reg_addr[IDX_CUR] = scatr_pkg::ADDR_VCO_CURRENT_CAL;
    assign reg_addr[IDX_COARSE] = scatr_pkg::ADDR_VCO_COARSE_CAP_CAL;
    assign reg_addr[IDX_CTL] = scatr_pkg::ADDR_SYNTH_CAL_CONTROL;
    assign reg_addr[IDX_TWA] = scatr_pkg::ADDR_TUNING_WORD_A;
    assign reg_addr[IDX_TWB] = scatr_pkg::ADDR_TUNING_WORD_B;
    assign reg_addr[IDX_TWC] = scatr_pkg::ADDR_TUNING_WORD_C;
    assign reg_addr[IDX_PE7] = scatr_pkg::ADDR_POWER_LEVEL_ENTRY_SEVEN;

    // One hit line per register, shared by the write and the read side
    for (genvar g = 0; g < REG_COUNT; g++) begin : g_decode
        assign addr_hit[g] = addr == reg_addr[g];
        assign wr_hit[g] = wr && addr_hit[g];
        assign rd_term[g] = addr_hit[g] ? reg_word[g] : scatr_pkg::RD_UNMAPPED;
    end

    // ************************
    // VCO current calibration
    // ************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur_r <= scatr_pkg::RST_VCO_CURRENT_CAL; // R1
        end else if (wr_hit[IDX_CUR]) begin
            cur_r <= wdata & scatr_pkg::MASK_VCO_CURRENT_CAL; // R1 R2 R13 R14
        end else if (cal.cal_current_we) begin
            // Calibration moves only the current field, core select stays software's
            cur_r <= {cur_r[7:scatr_pkg::VCO_HIGH_CORE_SELECT_BIT], cal.cal_current}; // R1
        end
    end

    // ******************************
    // VCO coarse capacitor calibration
    // ******************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            coarse_r <= scatr_pkg::RST_VCO_COARSE_CAP_CAL; // R3
        end else if (deep_sleep_wake) begin
            coarse_r <= scatr_pkg::RST_VCO_COARSE_CAP_CAL; // R4
        end else if (wr_hit[IDX_COARSE]) begin
            coarse_r <= wdata & scatr_pkg::MASK_VCO_COARSE_CAP_CAL; // R2 R3 R14
        end else if (cal.cal_coarse_we) begin
            coarse_r <= {2'h0, cal.cal_coarse}; // R3
        end
    end

    // *******************
    // Calibration control
    // *******************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctl_r <= scatr_pkg::RST_SYNTH_CAL_CONTROL; // R5
        end else if (wr_hit[IDX_CTL]) begin
            ctl_r <= wdata & scatr_pkg::MASK_SYNTH_CAL_CONTROL; // R5 R14
        end
    end

    // *************
    // Tuning word A
    // *************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            twa_r <= scatr_pkg::RST_TUNING_WORD_A; // R6
        end else if (wr_hit[IDX_TWA]) begin
            twa_r <= wdata; // R6
        end
    end

    // *************
    // Tuning word B
    // *************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            twb_r <= scatr_pkg::RST_TUNING_WORD_B; // R7
        end else if (wr_hit[IDX_TWB]) begin
            twb_r <= wdata; // R7 R8
        end
    end

    // *************
    // Tuning word C
    // *************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            twc_r <= scatr_pkg::RST_TUNING_WORD_C; // R10
        end else if (wr_hit[IDX_TWC]) begin
            twc_r <= wdata; // R10
        end
    end

    // *****************
    // Power entry seven
    // *****************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pe7_r <= scatr_pkg::RST_POWER_LEVEL_ENTRY_SEVEN; // R11
        end else if (wr_hit[IDX_PE7]) begin
            pe7_r <= wdata; // R11
        end
    end

    // **********
    // Read path
    // **********
    assign reg_word[IDX_CUR] = cur_r;
    assign reg_word[IDX_COARSE] = coarse_r;
    assign reg_word[IDX_CTL] = ctl_r;
    assign reg_word[IDX_TWA] = twa_r;
    assign reg_word[IDX_TWB] = twb_r;
    assign reg_word[IDX_TWC] = twc_r;
    assign reg_word[IDX_PE7] = pe7_r;

    // An unmapped address hits nothing, so the OR stays at the unmapped value
    always_comb begin
        rd_nxt = scatr_pkg::RD_UNMAPPED;
        for (int i = 0; i < REG_COUNT; i++) begin
            rd_nxt = rd_nxt | rd_term[i]; // R14
        end
    end

    // Read data held only in the cycle after the strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 8'h00;
        end else if (rd) begin
            rdata_r <= rd_nxt; // R14
        end else begin
            rdata_r <= 8'h00;
        end
    end
    assign rdata = rdata_r;

    // ****************
    // Analog-side outputs
    // ****************
    assign vco_current_cal = cur_r[scatr_pkg::VCO_CURRENT_MSB:0];
    assign vco_high_core_select = cur_r[scatr_pkg::VCO_HIGH_CORE_SELECT_BIT]; // R13
    assign vco_coarse_cap_cal = coarse_r[scatr_pkg::COARSE_CAP_MSB:0];
    assign synth_cal_control = ctl_r[scatr_pkg::CAL_CONTROL_MSB:0];
    assign tuning_word_a = twa_r;
    assign tuning_word_b = twb_r;
    assign tuning_word_c = twc_r;
    assign vco_choice_cal_enable = twc_r[scatr_pkg::VCO_CHOICE_CAL_ENABLE_BIT]; // R10

    scatr_power_sel u_power_sel (
        .clk(clk),
        .nrst(nrst),
        .power_index_select(power_index_select),
        .ramp_up(ramp_up),
        .ramp_down(ramp_down),
        .power_level_entry_seven(pe7_r),
        .power_level_low(power_level_low),
        .power_index(power_index),
        .power_level(power_level)
    );
endmodule
`default_nettype wire

// ==== verif/scatr_regs_chk.sv ====
// Port checks for the synth cal and tuning register bank
`timescale 1ns/10ps
`default_nettype none
module scatr_regs_chk (
    // Clock, reset, register port
    input wire logic clk,
    input wire logic nrst,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // Calibration, wake, power control
    input wire logic cal_current_we,
    input wire logic [4:0] cal_current,
    input wire logic deep_sleep_wake,
    input wire logic [2:0] power_index_select,
    input wire logic ramp_up,
    input wire logic ramp_down,
    // Register outputs
    input wire logic [4:0] vco_current_cal,
    input wire logic vco_high_core_select,
    input wire logic [5:0] vco_coarse_cap_cal,
    input wire logic [6:0] synth_cal_control,
    input wire logic vco_choice_cal_enable,
    input wire logic [2:0] power_index
);
    // **********
    // Assertions
    // **********
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    logic cur_wr;
    assign cur_wr = wr && addr == 16'hdf1d;
    chk_rdata_idle: assert property (!rd |=> rdata == 8'h00)
        else $error("rdata not idle");
    chk_wake_coarse: assert property (deep_sleep_wake |=> vco_coarse_cap_cal == 6'h20)
        else $error("coarse not reset on wake");
    chk_cal_current: assert property (
        cal_current_we && !cur_wr |=> vco_current_cal == $past(cal_current))
        else $error("cal current not taken");
    chk_current_hold: assert property (
        !cal_current_we && !cur_wr |=> $stable(vco_current_cal))
        else $error("current changed");
    chk_core_write: assert property (cur_wr |=> vco_high_core_select == $past(wdata[5]))
        else $error("core select not written");
    chk_ctrl_write: assert property (
        wr && addr == 16'hdf1f |=> synth_cal_control == $past(wdata[6:0]))
        else $error("cal control not written");
    chk_choice_write: assert property (
        wr && addr == 16'hdf25 |=> vco_choice_cal_enable == $past(wdata[1]))
        else $error("choice enable not written");
    chk_ramp_step: assert property (
        ramp_up && !ramp_down && power_index < power_index_select
        |=> power_index == $past(power_index) + 3'h1)
        else $error("ramp step wrong");
endmodule

bind scatr_regs scatr_regs_chk i_chk (
    .clk(clk),
    .nrst(nrst),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .cal_current_we(cal_current_we),
    .cal_current(cal_current),
    .deep_sleep_wake(deep_sleep_wake),
    .power_index_select(power_index_select),
    .ramp_up(ramp_up),
    .ramp_down(ramp_down),
    .vco_current_cal(vco_current_cal),
    .vco_high_core_select(vco_high_core_select),
    .vco_coarse_cap_cal(vco_coarse_cap_cal),
    .synth_cal_control(synth_cal_control),
    .vco_choice_cal_enable(vco_choice_cal_enable),
    .power_index(power_index)
);
`default_nettype wire

// ==== verif/tb_scatr_regs.sv ====
// Self-checking bench for the synth cal and tuning register bank
`timescale 1ns/10ps
`default_nettype none
module tb_scatr_regs;
    // *****************
    // Signals and tasks
    // *****************
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic deep_sleep_wake = 1'b0;
    logic [2:0] power_index_select = 3'h0;
    logic ramp_up = 1'b0;
    logic ramp_down = 1'b0;
    logic [7:0] lvl [7];
    logic [7:0] rdata, power_level;
    logic [4:0] vco_current_cal;
    logic [5:0] vco_coarse_cap_cal;
    logic [6:0] synth_cal_control;
    logic [2:0] power_index;
    logic vco_high_core_select, vco_choice_cal_enable;
    logic [7:0] tuning_word_a, tuning_word_b, tuning_word_c;
    logic cal_current_we = 1'b0;
    logic [4:0] cal_current = 5'h00;
    logic cal_coarse_we = 1'b0;
    logic [5:0] cal_coarse = 6'h00;
    logic [7:0] offs [7] = '{8'h1d, 8'h1e, 8'h1f, 8'h23, 8'h24, 8'h25, 8'h27};
    logic [7:0] rst_val [7] = '{8'h0a, 8'h20, 8'h0d, 8'h88, 8'h11, 8'h0b, 8'h00};
    logic [7:0] msk [7] = '{8'h3f, 8'h3f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff};
    int failures = 0;
    int n_checks = 0;
    scatr_regs i_dut (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .cal_current_we,
        .cal_current, .cal_coarse_we, .cal_coarse, .deep_sleep_wake, .power_index_select,
        .ramp_up, .ramp_down, .power_level_low(lvl), .vco_current_cal, .vco_high_core_select,
        .vco_coarse_cap_cal, .synth_cal_control, .tuning_word_a, .tuning_word_b,
        .tuning_word_c, .vco_choice_cal_enable, .power_index, .power_level);
    always #5 clk = ~clk;
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string n, input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(n, rdata, e);
    endtask
    task automatic wait_idx(input logic [2:0] t);
        for (int k = 0; k < 20; k++) begin
            @(posedge clk);
            #1;
            if (power_index === t) begin
                return;
            end
        end
        failures++;
        $display("mismatch power index expected %h seen %h", t, power_index);
    endtask
    initial begin
        for (int i = 0; i < 7; i++) begin
            lvl[i] = {5'h02, 3'(i)};
        end
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd_chk("reset", {8'hdf, offs[i]}, rst_val[i]);
        end
        chk("ctl out", {1'b0, synth_cal_control}, 8'h0d);
        for (int i = 0; i < 7; i++) begin
            wr_reg({8'hdf, offs[i]}, 8'hff);
            rd_chk("mask", {8'hdf, offs[i]}, msk[i]);
        end
        wr_reg(16'hdf20, 8'h5a);
        rd_chk("unmapped", 16'hdf20, 8'h00);
        wr_reg(16'hdf23, 8'h81);
        rd_chk("tune a", 16'hdf23, 8'h81);
        chk("tune a out", tuning_word_a, 8'h81);
        wr_reg(16'hdf24, 8'h31);
        rd_chk("tune b tx", 16'hdf24, 8'h31);
        chk("tune b tx out", tuning_word_b, 8'h31);
        wr_reg(16'hdf24, 8'h35);
        rd_chk("tune b rx", 16'hdf24, 8'h35);
        chk("tune b rx out", tuning_word_b, 8'h35);
        wr_reg(16'hdf25, 8'h09);
        #1;
        chk("choice", {7'h00, vco_choice_cal_enable}, 8'h00);
        chk("tune c out", tuning_word_c, 8'h09);
        @(posedge clk);
        cal_current_we <= 1'b1;
        cal_current <= 5'h15;
        cal_coarse_we <= 1'b1;
        cal_coarse <= 6'h2a;
        @(posedge clk);
        cal_current_we <= 1'b0;
        cal_coarse_we <= 1'b0;
        rd_chk("cal current", 16'hdf1d, 8'h35);
        chk("core out", {7'h00, vco_high_core_select}, 8'h01);
        rd_chk("cal coarse", 16'hdf1e, 8'h2a);
        @(posedge clk);
        addr <= 16'hdf1e;
        wdata <= 8'h3f;
        wr <= 1'b1;
        deep_sleep_wake <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        deep_sleep_wake <= 1'b0;
        #1;
        chk("wake coarse", {2'h0, vco_coarse_cap_cal}, 8'h20);
        chk("wake current", {3'h0, vco_current_cal}, 8'h15);
        wr_reg(16'hdf1e, 8'h2a);
        rd_chk("restore", 16'hdf1e, 8'h2a);
        @(posedge clk);
        addr <= 16'hdf1e;
        wdata <= 8'h07;
        wr <= 1'b1;
        cal_coarse_we <= 1'b1;
        cal_coarse <= 6'h15;
        @(posedge clk);
        wr <= 1'b0;
        cal_coarse_we <= 1'b0;
        rd_chk("write over cal", 16'hdf1e, 8'h07);
        wr_reg(16'hdf27, 8'h5a);
        power_index_select <= 3'h7;
        ramp_up <= 1'b1;
        wait_idx(3'h7);
        chk("level seven", power_level, 8'h5a);
        @(posedge clk);
        ramp_up <= 1'b0;
        power_index_select <= 3'h3;
        wait_idx(3'h3);
        chk("level three", power_level, 8'h13);
        @(posedge clk);
        ramp_down <= 1'b1;
        wait_idx(3'h0);
        chk("level zero", power_level, 8'h10);
        complete_run;
    end
endmodule
`default_nettype wire
